// File: core/hsdpm_cfg.svh
// Constants for the headset detect and pin mux block.
// Assumes a 200 MHz hclk and an AHB-Lite master with word accesses.
// Overview of operation
// R1 - Headset detection runs only while the detect enable bit 15 is one.
// R2 - Headset kind reads 00 none, 01 stereo, 10 cellular, 11 both.
// R3 - Headset kind is meaningful only while detection is enabled.
// R4 - Read-only bit 12 shows one while a headset is detected.
// R5 - Read-only bit 11 shows one while a button press is detected.
// R6 - Headset debounce 16 to 128 ms at 2 to 16 ms steps, reset 01.
// R7 - Button debounce off for 00, else 8, 16, 32 ms at 1, 2, 4 ms.
// R8 - Pin B carries headset interrupt if enabled and its general modes are off.
// R9 - Pin A carries detect interrupt if enabled and its general modes are off.
// R10 - Pin B clock is 256 times the faster of DAC and ADC sample rates.
// R11 - Clock mode needs PLL on, general modes off, no interrupt on pin B.
// R12 - Pin A function 0X tri-state, 10 button interrupt, 11 ADC word-select.
// R13 - Software picks word-select only when ADC and DAC rates must differ.
// R14 - Pin B output enable bit 15 drives the level of bit 14.
// R15 - Pin B input enable bit 13 makes bit 12 show the pin level.
// R16 - Pin A output enable bit 11 drives the level of bit 10.
// R17 - Pin A input enable bit 9 makes bit 8 show the pin level.
// R18 - Pin control bits 7 to 0 read zero; software writes zeros.
// R19 - Detect config bits 8 and 5 read zero; software writes zeros.
// R20 - Inputs are synchronised; flags change only after a stable interval, bar button debounce 00; pin bits 12 and 8 follow the synchronised pin unfiltered.
// R21 - General output or input mode wins over other functions, else tri-state.
`ifndef HSDPM_CFG_SVH
`define HSDPM_CFG_SVH
`define HSDPM_IDX_CFG 8'h22
`define HSDPM_IDX_PIN 8'h23
`define HSDPM_CLK_PS 5000
`define HSDPM_MS_PS 1000000000
`define HSDPM_TICK_CYC (`HSDPM_MS_PS / `HSDPM_CLK_PS)
`define HSDPM_TICK_W 18
`define HSDPM_DEB_SAMPLES 4'h8
`define HSDPM_HS_DEB_RST 2'h1
`define HSDPM_SYNC_W 6
`define HSDPM_S_PRES 0
`define HSDPM_S_STER 1
`define HSDPM_S_CELL 2
`define HSDPM_S_BTN 3
`define HSDPM_S_PA 4
`define HSDPM_S_PB 5
`define HSDPM_B_DETECT 15
`define HSDPM_B_KIND 14:13
`define HSDPM_B_PRES 12
`define HSDPM_B_BTN 11
`define HSDPM_B_HSDEB 10:9
`define HSDPM_B_BTDEB 7:6
`define HSDPM_B_IRQB 4
`define HSDPM_B_IRQA 3
`define HSDPM_B_CLKB 2
`define HSDPM_B_AFUNC 1:0
`define HSDPM_B_BOE 15
`define HSDPM_B_BLVL 14
`define HSDPM_B_BIE 13
`define HSDPM_B_BIN 12
`define HSDPM_B_AOE 11
`define HSDPM_B_ALVL 10
`define HSDPM_B_AIE 9
`define HSDPM_B_AIN 8
`endif

// File: core/hsdpm_pkg.sv
// Types for the headset detect and pin mux block.
// Assumes hsdpm_cfg.svh for register bit positions; the pin A encodings stand here.
package hsdpm_pkg;
  typedef enum logic [1:0] {
    HSDPM_A_TRI0 = 2'b00,
    HSDPM_A_TRI1 = 2'b01,
    HSDPM_A_BTN = 2'b10,
    HSDPM_A_ADC_WORD_SELECT = 2'b11
  } hsdpm_afunc_t;
  typedef struct packed {
    logic detect_en;
    logic [1:0] hs_deb;
    logic [1:0] bt_deb;
    logic irq_b;
    logic irq_a;
    logic clk_b;
    hsdpm_afunc_t a_func;
  } hsdpm_cfg_t;
  typedef struct packed {
    logic b_oe;
    logic b_lvl;
    logic b_ie;
    logic a_oe;
    logic a_lvl;
    logic a_ie;
  } hsdpm_pin_t;
  typedef struct packed {
    logic [1:0] kind;
    logic present;
    logic button;
    logic a_in;
    logic b_in;
  } hsdpm_flags_t;
endpackage : hsdpm_pkg

// File: core/hsdpm_debounce.sv
// Glitch filter: eight equal samples at a programmable millisecond step.
// Assumes a synchronised input and a one-cycle millisecond tick.
`timescale 1ns/1ps
`include "hsdpm_cfg.svh"
module hsdpm_debounce #(
  parameter int W = 1
)(
  input logic hclk,
  input logic hresetn,
  input logic en,
  input logic bypass,
  input logic ms_tick,
  input logic [2:0] res_shift,
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [4:0] ms_cnt;
  logic [3:0] samp_cnt;
  logic [W-1:0] cand;
  logic sample;
  assign sample = ms_tick && (ms_cnt == ((5'h1 << res_shift) - 5'h1)); // R6 R7
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 5'h0;
    end else if (!en || sample) begin
      ms_cnt <= 5'h0;
    end else if (ms_tick) begin
      ms_cnt <= ms_cnt + 5'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand <= '0;
      samp_cnt <= 4'h0;
      dout <= '0;
    end else if (!en) begin
      cand <= '0;
      samp_cnt <= 4'h0;
      dout <= '0;
    end else if (bypass) begin
      dout <= din; // R7
    end else if (sample) begin
      if (din != cand) begin
        cand <= din;
        samp_cnt <= 4'h1;
      end else if (samp_cnt >= `HSDPM_DEB_SAMPLES - 4'h1) begin
        dout <= cand; // R20
      end else begin
        samp_cnt <= samp_cnt + 4'h1;
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_flag_stable: assert property (en && !bypass ##1 $changed(dout) // R20
    |-> $past(samp_cnt) >= `HSDPM_DEB_SAMPLES - 4'h1 && $past(sample))
    else $error("filtered flag changed before a stable interval");
  a_bypass_follow: assert property (en && bypass |=> dout == $past(din)) // R7
    else $error("unfiltered flag does not follow its input");
endmodule : hsdpm_debounce

// File: core/hsdpm_clkdiv.sv
// Divider for the pin B clock output from two half-period counts.
// Assumes half periods in hclk cycles for 256 times each sample rate.
`timescale 1ns/1ps
module hsdpm_clkdiv (
  input logic hclk,
  input logic hresetn,
  input logic en,
  input logic [7:0] dac_half,
  input logic [7:0] adc_half,
  output logic clk_o
);
  logic [7:0] cnt;
  logic [7:0] half_m1;
  logic [7:0] fast;
  assign fast = (dac_half <= adc_half) ? dac_half : adc_half; // R10
  assign half_m1 = (fast == 8'h0) ? 8'h0 : fast - 8'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h0;
      clk_o <= 1'b0;
    end else if (!en) begin
      cnt <= 8'h0;
      clk_o <= 1'b0;
    end else if (cnt >= half_m1) begin
      cnt <= 8'h0;
      clk_o <= !clk_o; // R10
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_mid_half;
    en && cnt < half_m1 ##1 en;
  endsequence
  sequence s_end_half;
    en && cnt >= half_m1 ##1 en;
  endsequence
  a_clk_hold: assert property (s_mid_half |-> $stable(clk_o)) // R10
    else $error("clock output toggled inside a half period");
  a_clk_flip: assert property (s_end_half |-> $changed(clk_o)) // R10
    else $error("clock output missed its half period edge");
endmodule : hsdpm_clkdiv

// File: core/hsdpm_top.sv
// Headset detect, debounce and two-pin function mux with AHB-Lite registers.
// Assumes one hclk domain; jack, button and pin inputs are asynchronous.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "hsdpm_cfg.svh"
module hsdpm_top #(
  parameter int unsigned TICK_CYCLES = `HSDPM_TICK_CYC
)(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic jack_present_raw,
  input logic jack_stereo_raw,
  input logic jack_cell_raw,
  input logic button_raw,
  input logic pll_enabled,
  input logic [7:0] dac_half_period,
  input logic [7:0] adc_half_period,
  input logic adc_word_select,
  input logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  input logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  hsdpm_pkg::hsdpm_cfg_t cfg;
  hsdpm_pkg::hsdpm_cfg_t next_cfg;
  hsdpm_pkg::hsdpm_pin_t pin;
  hsdpm_pkg::hsdpm_pin_t next_pin;
  hsdpm_pkg::hsdpm_flags_t flags;
  logic [`HSDPM_SYNC_W-1:0] raw;
  logic [`HSDPM_SYNC_W-1:0] sync0;
  logic [`HSDPM_SYNC_W-1:0] sync1;
  logic [`HSDPM_TICK_W-1:0] tick_cnt;
  logic ms_tick;
  logic [2:0] hs_db;
  logic bt_db;
  logic [2:0] hs_res;
  logic [2:0] bt_res;
  logic bt_bypass;
  logic wr_pend;
  logic [1:0] wr_sel;
  logic rd_req;
  logic [1:0] ap_sel;
  logic [31:0] next_rdata;
  logic clk_mode;
  logic div_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: bit 0 detect config, bit 1 pin control
  function automatic logic [1:0] hsdpm_decode(input logic [31:0] a);
    hsdpm_decode = 2'h0;
    if (a[31:2] == {22'h0, `HSDPM_IDX_CFG}) begin
      hsdpm_decode = 2'h1;
    end
    if (a[31:2] == {22'h0, `HSDPM_IDX_PIN}) begin
      hsdpm_decode = 2'h2;
    end
  endfunction : hsdpm_decode

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  assign raw[`HSDPM_S_PRES] = jack_present_raw;
  assign raw[`HSDPM_S_STER] = jack_stereo_raw;
  assign raw[`HSDPM_S_CELL] = jack_cell_raw;
  assign raw[`HSDPM_S_BTN] = button_raw;
  assign raw[`HSDPM_S_PA] = pin_a_in;
  assign raw[`HSDPM_S_PB] = pin_b_in;

  genvar gi;
  generate
    for (gi = 0; gi < `HSDPM_SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync0[gi] <= 1'b0;
          sync1[gi] <= 1'b0;
        end else begin
          sync0[gi] <= raw[gi]; // R20
          sync1[gi] <= sync0[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond timebase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (tick_cnt == `HSDPM_TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + `HSDPM_TICK_W'(1);
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debouncers
  assign hs_res = {1'b0, cfg.hs_deb} + 3'h1; // R6
  assign bt_res = {1'b0, cfg.bt_deb} - 3'h1; // R7
  assign bt_bypass = (cfg.bt_deb == 2'h0); // R7

  hsdpm_debounce #(
    .W(3)
  ) u_hs_deb (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(cfg.detect_en),
    .bypass(1'b0),
    .ms_tick(ms_tick),
    .res_shift(hs_res),
    .din({sync1[`HSDPM_S_CELL], sync1[`HSDPM_S_STER], sync1[`HSDPM_S_PRES]}),
    .dout(hs_db)
  );

  hsdpm_debounce #(
    .W(1)
  ) u_bt_deb (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(cfg.detect_en),
    .bypass(bt_bypass),
    .ms_tick(ms_tick),
    .res_shift(bt_res),
    .din(sync1[`HSDPM_S_BTN]),
    .dout(bt_db)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags.kind <= 2'h0;
      flags.present <= 1'b0;
      flags.button <= 1'b0;
    end else if (!cfg.detect_en) begin
      flags.kind <= 2'h0; // R1 R3
      flags.present <= 1'b0;
      flags.button <= 1'b0;
    end else begin
      flags.present <= hs_db[0]; // R4
      flags.kind <= hs_db[0] ? hs_db[2:1] : 2'h0; // R2
      flags.button <= bt_db; // R5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags.a_in <= 1'b0;
      flags.b_in <= 1'b0;
    end else begin
      flags.a_in <= pin.a_ie ? sync1[`HSDPM_S_PA] : 1'b0; // R17
      flags.b_in <= pin.b_ie ? sync1[`HSDPM_S_PB] : 1'b0; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign ap_sel = hsdpm_decode(haddr);
  assign rd_req = hsel && htrans[1] && hready && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel <= 2'h0;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_sel <= ap_sel;
    end
  end

  always_comb begin
    next_cfg = cfg;
    if (wr_pend && wr_sel[0]) begin
      next_cfg.detect_en = hwdata[`HSDPM_B_DETECT];
      next_cfg.hs_deb = hwdata[`HSDPM_B_HSDEB];
      next_cfg.bt_deb = hwdata[`HSDPM_B_BTDEB];
      next_cfg.irq_b = hwdata[`HSDPM_B_IRQB];
      next_cfg.irq_a = hwdata[`HSDPM_B_IRQA];
      next_cfg.clk_b = hwdata[`HSDPM_B_CLKB];
      next_cfg.a_func = hsdpm_pkg::hsdpm_afunc_t'(hwdata[`HSDPM_B_AFUNC]);
    end
  end

  always_comb begin
    next_pin = pin;
    if (wr_pend && wr_sel[1]) begin
      next_pin.b_oe = hwdata[`HSDPM_B_BOE];
      next_pin.b_lvl = hwdata[`HSDPM_B_BLVL];
      next_pin.b_ie = hwdata[`HSDPM_B_BIE];
      next_pin.a_oe = hwdata[`HSDPM_B_AOE];
      next_pin.a_lvl = hwdata[`HSDPM_B_ALVL];
      next_pin.a_ie = hwdata[`HSDPM_B_AIE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{detect_en: 1'b0, hs_deb: `HSDPM_HS_DEB_RST, bt_deb: 2'h0,
               irq_b: 1'b0, irq_a: 1'b0, clk_b: 1'b0,
               a_func: hsdpm_pkg::HSDPM_A_TRI0}; // R6
      pin <= '0;
    end else begin
      cfg <= next_cfg; // R1
      pin <= next_pin;
    end
  end

  // Read mux sees a write still in its data phase
  always_comb begin
    next_rdata = 32'h0; // R18 R19
    if (ap_sel[0]) begin
      next_rdata[`HSDPM_B_DETECT] = next_cfg.detect_en;
      next_rdata[`HSDPM_B_KIND] = flags.kind;
      next_rdata[`HSDPM_B_PRES] = flags.present;
      next_rdata[`HSDPM_B_BTN] = flags.button;
      next_rdata[`HSDPM_B_HSDEB] = next_cfg.hs_deb;
      next_rdata[`HSDPM_B_BTDEB] = next_cfg.bt_deb;
      next_rdata[`HSDPM_B_IRQB] = next_cfg.irq_b;
      next_rdata[`HSDPM_B_IRQA] = next_cfg.irq_a;
      next_rdata[`HSDPM_B_CLKB] = next_cfg.clk_b;
      next_rdata[`HSDPM_B_AFUNC] = next_cfg.a_func;
    end
    if (ap_sel[1]) begin
      next_rdata[`HSDPM_B_BOE] = next_pin.b_oe;
      next_rdata[`HSDPM_B_BLVL] = next_pin.b_lvl;
      next_rdata[`HSDPM_B_BIE] = next_pin.b_ie;
      next_rdata[`HSDPM_B_BIN] = flags.b_in;
      next_rdata[`HSDPM_B_AOE] = next_pin.a_oe;
      next_rdata[`HSDPM_B_ALVL] = next_pin.a_lvl;
      next_rdata[`HSDPM_B_AIE] = next_pin.a_ie;
      next_rdata[`HSDPM_B_AIN] = flags.a_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= rd_req ? next_rdata : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived clock for pin B
  assign clk_mode = cfg.clk_b && pll_enabled && !pin.b_oe && !pin.b_ie
                    && !cfg.irq_b; // R11

  hsdpm_clkdiv u_clkdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(clk_mode),
    .dac_half(dac_half_period),
    .adc_half(adc_half_period),
    .clk_o(div_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin A function mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_oe <= 1'b0;
      pin_a_out <= 1'b0;
    end else if (pin.a_oe) begin
      pin_a_oe <= 1'b1; // R16 R21
      pin_a_out <= pin.a_lvl;
    end else if (pin.a_ie) begin
      pin_a_oe <= 1'b0; // R21
      pin_a_out <= 1'b0;
    end else if (cfg.irq_a) begin
      pin_a_oe <= 1'b1; // R9
      pin_a_out <= flags.present || flags.button;
    end else begin
      unique case (cfg.a_func)
        hsdpm_pkg::HSDPM_A_TRI0, hsdpm_pkg::HSDPM_A_TRI1: begin
          pin_a_oe <= 1'b0; // R12
          pin_a_out <= 1'b0;
        end
        hsdpm_pkg::HSDPM_A_BTN: begin
          pin_a_oe <= 1'b1; // R12
          pin_a_out <= flags.button;
        end
        hsdpm_pkg::HSDPM_A_ADC_WORD_SELECT: begin
          pin_a_oe <= 1'b1; // R12 R13
          pin_a_out <= adc_word_select;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin B function mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_b_oe <= 1'b0;
      pin_b_out <= 1'b0;
    end else if (pin.b_oe) begin
      pin_b_oe <= 1'b1; // R14 R21
      pin_b_out <= pin.b_lvl;
    end else if (pin.b_ie) begin
      pin_b_oe <= 1'b0; // R21
      pin_b_out <= 1'b0;
    end else if (cfg.irq_b) begin
      pin_b_oe <= 1'b1; // R8
      pin_b_out <= flags.present;
    end else if (clk_mode) begin
      pin_b_oe <= 1'b1; // R10 R11
      pin_b_out <= div_clk;
    end else begin
      pin_b_oe <= 1'b0; // R21
      pin_b_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_pin_a_free;
    !pin.a_oe && !pin.a_ie && !cfg.irq_a;
  endsequence
  sequence s_cfg_read;
    rd_req && ap_sel[0];
  endsequence
  sequence s_pin_read;
    rd_req && ap_sel[1];
  endsequence

  a_detect_off_flags: assert property (!cfg.detect_en [*2] // R1
    |-> !flags.present && !flags.button)
    else $error("flags set while detection is disabled");
  a_kind_code: assert property (flags.kind != 2'h0 |-> flags.present) // R2
    else $error("headset kind nonzero with no headset present");
  a_kind_off: assert property (!cfg.detect_en [*2] |-> flags.kind == 2'h0) // R3
    else $error("headset kind nonzero while detection is disabled");
  a_present_src: assert property (cfg.detect_en ##1 cfg.detect_en // R4
    |-> flags.present == $past(hs_db[0]))
    else $error("presence flag does not follow the filtered level");
  a_button_src: assert property (cfg.detect_en ##1 cfg.detect_en // R5
    |-> flags.button == $past(bt_db))
    else $error("button flag does not follow the filtered level");
  a_pin_b_drive: assert property (pin.b_oe // R14
    |=> pin_b_oe && pin_b_out == $past(pin.b_lvl))
    else $error("pin B not driven at its programmed level");
  a_pin_a_drive: assert property (pin.a_oe // R16
    |=> pin_a_oe && pin_a_out == $past(pin.a_lvl))
    else $error("pin A not driven at its programmed level");
  a_pin_b_sense: assert property (pin.b_ie // R15
    |=> flags.b_in == $past(sync1[`HSDPM_S_PB]))
    else $error("pin B input flag does not track the pin");
  a_pin_a_sense: assert property (pin.a_ie // R17
    |=> flags.a_in == $past(sync1[`HSDPM_S_PA]))
    else $error("pin A input flag does not track the pin");
  a_pin_a_tristate: assert property (!pin.a_oe && pin.a_ie |=> !pin_a_oe) // R21
    else $error("pin A driven while in input mode");
  a_pin_a_irq: assert property (!pin.a_oe && !pin.a_ie && cfg.irq_a // R9
    |=> pin_a_oe && pin_a_out == $past(flags.present || flags.button))
    else $error("pin A does not carry the detect interrupt");
  a_pin_b_irq: assert property (!pin.b_oe && !pin.b_ie && cfg.irq_b // R8
    |=> pin_b_oe && pin_b_out == $past(flags.present))
    else $error("pin B does not carry the headset interrupt");
  a_pin_a_wsel: assert property (s_pin_a_free // R12
    and cfg.a_func == hsdpm_pkg::HSDPM_A_ADC_WORD_SELECT
    |=> pin_a_oe && pin_a_out == $past(adc_word_select))
    else $error("pin A does not carry the ADC word-select");
  a_clk_gate: assert property (!pll_enabled && !pin.b_oe && !cfg.irq_b // R11
    |=> !pin_b_oe)
    else $error("pin B driven in clock mode without the PLL");
  a_rsv_cfg: assert property (s_cfg_read // R19
    |=> hrdata[8] == 1'b0 && hrdata[5] == 1'b0 && hrdata[31:16] == 16'h0)
    else $error("reserved detect config bits read nonzero");
  a_rsv_pin: assert property (s_pin_read |=> hrdata[7:0] == 8'h0) // R18
    else $error("reserved pin control bits read nonzero");

endmodule : hsdpm_top

// File: testbench/hsdpm_jack.sv
// Far-side model: headset jack contacts, button and the two external pin wires.
// Assumes the bench sets plug state and the level an outside driver puts on idle pins.
`timescale 1ns/1ps
module hsdpm_jack (
  input logic plugged,
  input logic [1:0] kind,
  input logic pressed,
  input logic ext_a,
  input logic ext_b,
  input logic pin_a_out,
  input logic pin_a_oe,
  input logic pin_b_out,
  input logic pin_b_oe,
  output logic present_raw,
  output logic stereo_raw,
  output logic cell_raw,
  output logic button_raw,
  output logic pin_a_wire,
  output logic pin_b_wire
);
  // Jack contacts close only while a plug sits in the jack; the button follows pressed alone
  assign present_raw = plugged;
  assign stereo_raw = plugged & kind[0];
  assign cell_raw = plugged & kind[1];
  assign button_raw = pressed;
  // Device wins the wire while driving, else the outside driver
  assign pin_a_wire = pin_a_oe ? pin_a_out : ext_a;
  assign pin_b_wire = pin_b_oe ? pin_b_out : ext_b;
endmodule : hsdpm_jack

// File: testbench/hsdpm_top_tb.sv
// Self-checking bench for the headset detect and pin mux block.
// Assumes a millisecond tick shortened to ten hclk cycles.
`timescale 1ns/1ps
module hsdpm_top_tb;
  localparam int TK = 10;
  localparam logic [31:0] CA = 32'h0000_0088;
  localparam logic [31:0] PA = 32'h0000_008c;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pll, aws;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, kind;
  logic [2:0] hsize;
  logic [7:0] dh, ah;
  logic pres_r, ster_r, cell_r, btn_r, a_in, b_in, a_out, a_oe, b_out, b_oe;
  logic plugged, pressed, ext_a, ext_b;
  int n_mismatch, n_checks;
  hsdpm_top #(.TICK_CYCLES(TK)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .jack_present_raw(pres_r), .jack_stereo_raw(ster_r), .jack_cell_raw(cell_r),
    .button_raw(btn_r), .pll_enabled(pll), .dac_half_period(dh), .adc_half_period(ah),
    .adc_word_select(aws), .pin_a_in(a_in), .pin_a_out(a_out), .pin_a_oe(a_oe),
    .pin_b_in(b_in), .pin_b_out(b_out), .pin_b_oe(b_oe));
  hsdpm_jack far (.plugged(plugged), .kind(kind), .pressed(pressed), .ext_a(ext_a),
    .ext_b(ext_b), .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_out(b_out),
    .pin_b_oe(b_oe), .present_raw(pres_r), .stereo_raw(ster_r), .cell_raw(cell_r),
    .button_raw(btn_r), .pin_a_wire(a_in), .pin_b_wire(b_in));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic wt;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wt
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask : wr
  task automatic rd(input logic [31:0] a, input string s, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    wt();
    chk(s, e, hrdata);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  task automatic pins(input logic [3:0] e);
    chk("pins", {28'h0, e}, {28'h0, a_oe, a_out, b_oe, b_out});
  endtask : pins
  task automatic meas(input int e);
    logic prev;
    int t[$];
    prev = b_out;
    for (int i = 0; i < 60; i++) begin
      cyc(1);
      if (b_out === 1'b1 && prev === 1'b0) t.push_back(i);
      prev = b_out;
    end
    chk("clk_period", e, (t.size() > 2) ? t[2] - t[1] : 0);
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(CA, "cfg_rst", 32'h0000_0200);
    rd(PA, "pin_rst", 32'h0);
    wr(32'h0000_0090, 32'hffff_ffff);
    rd(32'h0000_0090, "unmapped", 32'h0);
    pins(4'h0);
  endtask : t_reset
  task automatic t_regs;
    wr(CA, 32'h0000_fedf);
    rd(CA, "cfg_all", 32'h0000_86df);
    wr(PA, 32'h0000_ff00);
    cyc(6);
    rd(PA, "pin_all", 32'h0000_ff00);
    pins(4'hf);
    wr(PA, 32'h0000_4400);
    cyc(3);
    pins(4'b1010);
    wr(CA, 32'h0);
    cyc(3);
    pins(4'h0);
  endtask : t_regs
  task automatic t_gpin;
    wr(CA, 32'h0000_8018);
    wr(PA, 32'h0000_2200);
    ext_a <= 1'b1;
    cyc(6);
    rd(PA, "pin_in", 32'h0000_2300);
    ext_a <= 1'b0;
    ext_b <= 1'b1;
    cyc(6);
    rd(PA, "pin_in", 32'h0000_3200);
    pins(4'h0);
    wr(PA, 32'h0);
    wr(CA, 32'h0);
  endtask : t_gpin
  task automatic t_headset;
    int st;
    for (int c = 0; c < 4; c++) begin
      st = TK * (2 << c);
      wr(CA, 32'h8018 | (c << 9));
      plugged <= 1'b1;
      kind <= c[1:0];
      cyc(6 * st);
      rd(CA, "hs_early", 32'h8018 | (c << 9));
      cyc(4 * st);
      rd(CA, "hs_kind", 32'h9018 | (c << 13) | (c << 9));
      pins(4'hf);
      wr(CA, 32'h0018);
      cyc(3);
      rd(CA, "hs_off", 32'h0018);
      plugged <= 1'b0;
    end
  endtask : t_headset
  task automatic t_button;
    int st;
    for (int c = 0; c < 4; c++) begin
      st = (c == 0) ? 0 : TK * (1 << (c - 1));
      wr(CA, 32'h8000 | (c << 6));
      pressed <= 1'b1;
      if (c != 0) begin
        cyc(6 * st);
        rd(CA, "bt_early", 32'h8000 | (c << 6));
      end
      cyc(4 * st + 6);
      rd(CA, "bt_flag", 32'h8800 | (c << 6));
      wr(CA, 32'h0);
      pressed <= 1'b0;
    end
  endtask : t_button
  task automatic t_mux;
    wr(CA, 32'h0000_8002);
    pressed <= 1'b1;
    cyc(8);
    pins(4'b1100);
    pressed <= 1'b0;
    dh <= 8'h02;
    ah <= 8'h03;
    wr(CA, 32'h0000_8003);
    aws <= 1'b1;
    cyc(4);
    pins(4'b1100);
    aws <= 1'b0;
    cyc(4);
    pins(4'b1000);
    wr(CA, 32'h0000_8001);
    cyc(3);
    pins(4'h0);
    wr(CA, 32'h0000_0004);
    pll <= 1'b1;
    cyc(10);
    meas(4);
    dh <= 8'h05;
    cyc(10);
    meas(6);
    pll <= 1'b0;
    cyc(4);
    pins(4'h0);
    pll <= 1'b1;
    wr(CA, 32'h0000_8014);
    cyc(4);
    pins(4'b0010);
    wr(CA, 32'h0);
  endtask : t_mux
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    cyc(20000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {hresetn, hsel, hwrite, pll, aws, plugged, pressed, ext_a, ext_b} = 9'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    kind = 2'h0;
    dh = 8'h02;
    ah = 8'h03;
    cyc(10);
    hresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_regs();
    t_gpin();
    t_headset();
    t_button();
    t_mux();
    finish_test();
  end
endmodule : hsdpm_top_tb
